/* rmli_ext_src.sv */
module rmli_ext_src (
    // Commands from the bench
    input wire logic clk_i,
    input wire logic rst_cmd_i,
    input wire logic [3:0] pin_cmd_i,
    // Pins towards the block
    output logic rst_n_o,
    output logic [3:0] pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rst_n_o = 1'b0;
        pin_n_o = 4'hf;
    end
    always @(posedge clk_i) begin
        rst_n_o <= ~rst_cmd_i;
        pin_n_o <= ~pin_cmd_i;
    end
endmodule

/* rmli_params.svh */
`ifndef RMLI_PARAMS_SVH
`define RMLI_PARAMS_SVH

// Register port geometry
`define RMLI_ADDR_W 3
`define RMLI_DATA_W 8
`define RMLI_NPIN 4

// Register offsets
`define RMLI_ADDR_EDGE 3'h0
`define RMLI_ADDR_MASK 3'h1
`define RMLI_ADDR_STATUS 3'h2
`define RMLI_ADDR_MODE 3'h3
`define RMLI_ADDR_PINS 3'h4

// Reset values
`define RMLI_EDGE_RST 4'h0
`define RMLI_MASK_RST 4'h0
`define RMLI_STATUS_RST 4'h0
`define RMLI_MODE_RST 4'h0
`define RMLI_PINS_RST 4'hf
`define RMLI_RSTSYNC_RST 2'h0
`define RMLI_PHASE_RST 2'h0
`define RMLI_DATA_RST 8'h00
`define RMLI_PIN_IDLE 1'b1
`define RMLI_PEND_RST 1'b0

// Field positions
`define RMLI_FLD_WAIT 4
`define RMLI_FLD_STOP 5
`define RMLI_PIN_A 0

`endif

/* rmli_pkg.sv */
`include "rmli_params.svh"

package rmli_pkg;

    typedef struct packed {
        logic [`RMLI_ADDR_W-1:0] addr;
        logic [`RMLI_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rmli_bus_type;

    typedef enum logic [1:0] {
        RMLI_PWR_RUN,
        RMLI_PWR_WAIT,
        RMLI_PWR_STOP
    } rmli_pwr_type;

endpackage

/* rmli_top.sv */
`include "rmli_params.svh"

module rmli_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Mode select and interrupt request pins, active low
    input wire logic mode_select_pin_a_n_i,
    input wire logic mode_select_pin_b_n_i,
    input wire logic mode_select_pin_c_n_i,
    input wire logic mode_select_pin_d_n_i,
    // Core power requests
    input wire logic wait_req_i,
    input wire logic stop_req_i,
    // Register port
    input wire rmli_pkg::rmli_bus_type bus_i,
    output logic [`RMLI_DATA_W-1:0] rdata_o,
    // Status towards the core
    output logic core_rst_n_o,
    output logic [1:0] phase_o,
    output logic [`RMLI_NPIN-1:0] operating_mode_register_o,
    output logic [`RMLI_NPIN-1:0] int_req_o,
    output logic irq_o,
    output logic wait_o,
    output logic stop_o,
    output logic wake_o
);
    import rmli_pkg::*;

    logic [`RMLI_NPIN-1:0] pin_n;
    logic [`RMLI_NPIN-1:0] pin_sync_n;
    logic run_sync;
    logic [1:0] phase_reg, phase_next;
    logic [`RMLI_NPIN-1:0] mode_reg, mode_next;
    logic [`RMLI_NPIN-1:0] edge_reg, edge_next;
    logic [`RMLI_NPIN-1:0] mask_reg, mask_next;
    logic [`RMLI_NPIN-1:0] status_reg;
    logic [`RMLI_NPIN-1:0] int_req_reg, int_req_next;
    logic irq_reg, irq_next;
    logic [`RMLI_DATA_W-1:0] rdata_reg, rdata_next;
    logic wait_reg;
    logic stop_reg;
    logic wake_reg;
    logic in_run;
    logic [`RMLI_NPIN-1:0] asserted;
    logic [`RMLI_NPIN-1:0] w1c;

    // Pin D is the top bit, pin A the bottom bit
    assign pin_n = {mode_select_pin_d_n_i, mode_select_pin_c_n_i,
                    mode_select_pin_b_n_i, mode_select_pin_a_n_i};

    // Release of reset passes two flops; assertion stays asynchronous
    rmli_rst_sync u_rmli_rst_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .run_o(run_sync)
    );

    assign in_run = run_sync;

    // Phase generator and mode capture
    always_comb begin
        phase_next = in_run ? phase_reg + 2'h1 : `RMLI_PHASE_RST;
        mode_next = in_run ? mode_reg : pin_sync_n;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= `RMLI_PHASE_RST;
            mode_reg <= `RMLI_MODE_RST;
        end else begin
            phase_reg <= phase_next;
            mode_reg <= mode_next;
        end
    end

    // One request channel per pin: synchroniser, edge detect and pending bit
    genvar g;
    generate
        for (g = 0; g < `RMLI_NPIN; g++) begin : gen_chan
            rmli_irq_chan u_rmli_irq_chan (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .pin_n_i(pin_n[g]),
                .in_run_i(in_run),
                .edge_mode_i(edge_reg[g]),
                .clear_i(w1c[g]),
                .pin_sync_n_o(pin_sync_n[g]),
                .asserted_o(asserted[g]),
                .pending_o(status_reg[g])
            );
        end
    endgenerate

    assign w1c = (bus_i.wr && bus_i.addr == `RMLI_ADDR_STATUS) ?
                 bus_i.wdata[`RMLI_NPIN-1:0] : `RMLI_STATUS_RST;

    // Configuration, pending and interrupt state
    always_comb begin
        edge_next = edge_reg;
        mask_next = mask_reg;
        if (bus_i.wr && bus_i.addr == `RMLI_ADDR_EDGE) begin
            edge_next = bus_i.wdata[`RMLI_NPIN-1:0];
        end
        if (bus_i.wr && bus_i.addr == `RMLI_ADDR_MASK) begin
            mask_next = bus_i.wdata[`RMLI_NPIN-1:0];
        end
        int_req_next = status_reg & mask_reg;
        irq_next = |(status_reg & mask_reg);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edge_reg <= `RMLI_EDGE_RST;
            mask_reg <= `RMLI_MASK_RST;
            int_req_reg <= `RMLI_STATUS_RST;
            irq_reg <= 1'b0;
        end else begin
            edge_reg <= edge_next;
            mask_reg <= mask_next;
            int_req_reg <= int_req_next;
            irq_reg <= irq_next;
        end
    end

    // Power state of the core
    rmli_pwr_ctl u_rmli_pwr_ctl (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_run_i(in_run),
        .wait_req_i(wait_req_i),
        .stop_req_i(stop_req_i),
        .asserted_i(asserted),
        .wait_o(wait_reg),
        .stop_o(stop_reg),
        .wake_o(wake_reg)
    );

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_next = `RMLI_DATA_RST;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `RMLI_ADDR_EDGE: rdata_next[`RMLI_NPIN-1:0] = edge_reg;
                `RMLI_ADDR_MASK: rdata_next[`RMLI_NPIN-1:0] = mask_reg;
                `RMLI_ADDR_STATUS: rdata_next[`RMLI_NPIN-1:0] = status_reg;
                `RMLI_ADDR_MODE: rdata_next[`RMLI_NPIN-1:0] = mode_reg;
                `RMLI_ADDR_PINS: begin
                    rdata_next[`RMLI_NPIN-1:0] = asserted;
                    rdata_next[`RMLI_FLD_WAIT] = wait_reg;
                    rdata_next[`RMLI_FLD_STOP] = stop_reg;
                end
                default: rdata_next = `RMLI_DATA_RST;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= `RMLI_DATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign core_rst_n_o = run_sync;
    assign phase_o = phase_reg;
    assign operating_mode_register_o = mode_reg;
    assign int_req_o = int_req_reg;
    assign irq_o = irq_reg;
    assign wait_o = wait_reg;
    assign stop_o = stop_reg;
    assign wake_o = wake_reg;

endmodule

// Two-flop release synchroniser for the active-low reset pin
module rmli_rst_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Run flag, low while the chip is held in reset
    output logic run_o
);
    logic [1:0] pipe_reg, pipe_next;

    always_comb begin
        pipe_next = {pipe_reg[0], 1'b1};
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pipe_reg <= `RMLI_RSTSYNC_RST;
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    assign run_o = pipe_reg[1];
endmodule

// One request pin: two-flop synchroniser, falling edge detect, sticky pending bit
module rmli_irq_chan (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Pin and controls
    input wire logic pin_n_i,
    input wire logic in_run_i,
    input wire logic edge_mode_i,
    input wire logic clear_i,
    // Results
    output logic pin_sync_n_o,
    output logic asserted_o,
    output logic pending_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg, prev_next;
    logic pending_reg, pending_next;
    logic fell;
    logic event_set;

    // Data only, so the synchroniser carries no reset
    always_ff @(posedge mclk_i) begin
        meta_reg <= pin_n_i;
        sync_reg <= meta_reg;
    end

    assign asserted_o = !sync_reg && in_run_i;
    assign fell = prev_reg && !sync_reg && in_run_i;
    assign event_set = edge_mode_i ? fell : asserted_o;

    always_comb begin
        prev_next = sync_reg;
        // A new event wins over a clear in the same cycle
        pending_next = (pending_reg && !clear_i) || event_set;
    end

    // Previous level resets to idle so no false edge follows reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= `RMLI_PIN_IDLE;
            pending_reg <= `RMLI_PEND_RST;
        end else begin
            prev_reg <= prev_next;
            pending_reg <= pending_next;
        end
    end

    assign pin_sync_n_o = sync_reg;
    assign pending_o = pending_reg;
endmodule

// Power state: Wait ends on any request, Stop only on pin A
module rmli_pwr_ctl (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Run flag, power requests and synchronised request levels
    input wire logic in_run_i,
    input wire logic wait_req_i,
    input wire logic stop_req_i,
    input wire logic [`RMLI_NPIN-1:0] asserted_i,
    // State towards the core
    output logic wait_o,
    output logic stop_o,
    output logic wake_o
);
    import rmli_pkg::*;

    rmli_pwr_type pwr_reg, pwr_next;
    logic wait_reg, wait_next;
    logic stop_reg, stop_next;
    logic wake_reg, wake_next;

    always_comb begin
        pwr_next = pwr_reg;
        wake_next = 1'b0;
        case (pwr_reg)
            RMLI_PWR_RUN: begin
                if (stop_req_i) begin
                    pwr_next = RMLI_PWR_STOP;
                end else if (wait_req_i) begin
                    pwr_next = RMLI_PWR_WAIT;
                end
            end
            RMLI_PWR_WAIT: begin
                if (|asserted_i) begin
                    pwr_next = RMLI_PWR_RUN;
                    wake_next = 1'b1;
                end
            end
            RMLI_PWR_STOP: begin
                if (asserted_i[`RMLI_PIN_A]) begin
                    pwr_next = RMLI_PWR_RUN;
                    wake_next = 1'b1;
                end
            end
            default: begin
                pwr_next = RMLI_PWR_RUN;
            end
        endcase
        if (!in_run_i) begin
            pwr_next = RMLI_PWR_RUN;
            wake_next = 1'b0;
        end
        wait_next = (pwr_next == RMLI_PWR_WAIT);
        stop_next = (pwr_next == RMLI_PWR_STOP);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_reg <= RMLI_PWR_RUN;
            wait_reg <= 1'b0;
            stop_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            wait_reg <= wait_next;
            stop_reg <= stop_next;
            wake_reg <= wake_next;
        end
    end

    assign wait_o = wait_reg;
    assign stop_o = stop_reg;
    assign wake_o = wake_reg;
endmodule

/* rmli_top_monitor.sv */
module rmli_top_monitor (
    // Clock, reset and pins
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic mode_select_pin_a_n_i,
    input wire logic mode_select_pin_b_n_i,
    input wire logic mode_select_pin_c_n_i,
    input wire logic mode_select_pin_d_n_i,
    // Core side
    input wire logic core_rst_n_o,
    input wire logic [1:0] phase_o,
    input wire logic [3:0] operating_mode_register_o,
    input wire logic [3:0] int_req_o,
    input wire logic irq_o,
    input wire logic wait_o,
    input wire logic stop_o,
    input wire logic wake_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] pins;
    assign pins = {mode_select_pin_d_n_i, mode_select_pin_c_n_i, mode_select_pin_b_n_i,
        mode_select_pin_a_n_i};
    sequence s_rel;
        !core_rst_n_o [*2] ##1 core_rst_n_o;
    endsequence
    sequence s_wake(st);
        ##[1:4] (wake_o && !st);
    endsequence
    AST_RST_HOLD: assert property (disable iff (1'b0)
        !rst_n_i && $past(!rst_n_i) |-> !core_rst_n_o && !phase_o)
        else $error("core not held in reset");
    AST_SYNC_REL: assert property ($rose(rst_n_i) |-> s_rel)
        else $error("reset release timing");
    AST_PHASE_START: assert property ($rose(core_rst_n_o) |-> !phase_o ##1 phase_o == 2'h1)
        else $error("phase start");
    AST_PHASE_STEP: assert property (core_rst_n_o && $past(core_rst_n_o) |->
        phase_o == $past(phase_o) + 2'h1) else $error("phase step");
    AST_MODE_CAP: assert property ($rose(core_rst_n_o) |->
        operating_mode_register_o == $past(pins, 3)) else $error("mode capture");
    AST_MODE_HOLD: assert property (core_rst_n_o && $past(core_rst_n_o) |->
        $stable(operating_mode_register_o)) else $error("mode changed");
    AST_IRQ_LVL: assert property (irq_o == (|int_req_o))
        else $error("irq level");
    AST_WAKE_WAIT: assert property (wait_o && |($past(pins) & ~pins) |-> s_wake(wait_o))
        else $error("wait not ended");
    AST_WAKE_STOP: assert property (stop_o && $fell(mode_select_pin_a_n_i) |-> s_wake(stop_o))
        else $error("stop not ended");
endmodule

/* rmli_top_tb_top.sv */
module rmli_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rmli_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_cmd = 1'b1;
    logic [3:0] pin_cmd = 4'h0;
    logic wait_req_i = 1'b0;
    logic stop_req_i = 1'b0;
    rmli_bus_type bus_i = '0;
    logic rst_n_i, core_rst_n_o, irq_o, wait_o, stop_o, wake_o;
    logic rd_q = 1'b0;
    logic [3:0] pin_n, mode_o, int_req_o;
    logic [7:0] rdata_o;
    logic [1:0] phase_o;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'h4c;
    int mismatches = 0;
    int num_checks = 0;
    initial forever #5 mclk_i = ~mclk_i;
    rmli_ext_src u_rmli_ext_src (.clk_i(mclk_i), .rst_cmd_i(rst_cmd), .pin_cmd_i(pin_cmd),
        .rst_n_o(rst_n_i), .pin_n_o(pin_n));
    rmli_top u_rmli_top (.mclk_i, .rst_n_i, .mode_select_pin_a_n_i(pin_n[0]),
        .mode_select_pin_b_n_i(pin_n[1]), .mode_select_pin_c_n_i(pin_n[2]),
        .mode_select_pin_d_n_i(pin_n[3]), .wait_req_i, .stop_req_i, .bus_i, .rdata_o,
        .core_rst_n_o, .phase_o, .operating_mode_register_o(mode_o), .int_req_o, .irq_o,
        .wait_o, .stop_o, .wake_o);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(ref logic s);
        int c;
        c = 0;
        while (s !== 1'b1 && c < 20) begin
            @(posedge mclk_i);
            c++;
        end
        if (s !== 1'b1) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk_i);
        bus_i <= '{a, d, w, !w};
        @(posedge mclk_i);
        bus_i <= '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask
    task automatic req(input logic s);
        @(posedge mclk_i);
        wait_req_i <= !s;
        stop_req_i <= s;
        @(posedge mclk_i);
        wait_req_i <= 1'b0;
        stop_req_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic do_reset(input logic [3:0] lv, input int cyc);
        @(posedge mclk_i);
        rst_cmd <= 1'b1;
        pin_cmd <= ~lv;
        repeat (cyc) @(posedge mclk_i);
        chk({6'h00, phase_o, core_rst_n_o}, 8'h00);
        rst_cmd <= 1'b0;
        wait_on(core_rst_n_o);
        chk({4'h0, mode_o}, {4'h0, lv});
        rd(3'h3, {4'h0, lv});
        pin_cmd <= 4'h0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(negedge mclk_i) begin
        if (rd_q)
            chk(rdata_o, expq.pop_front());
        rd_q <= bus_i.rd;
    end
    initial begin
        do_reset(4'hf, 20);
        for (int k = 0; k < 16; k++)
            do_reset(k[3:0], 6);
        $display("mode test done");
        seed = xs(seed);
        bus(3'h1, {4'h0, seed[3:0]}, 1'b1);
        bus(3'h2, 8'hff, 1'b1);
        pin_cmd <= 4'hf;
        repeat (6) @(posedge mclk_i);
        rd(3'h2, 8'h0f);
        chk({3'h0, irq_o, int_req_o}, {3'h0, |seed[3:0], seed[3:0]});
        bus(3'h2, 8'hff, 1'b1);
        rd(3'h2, 8'h0f);
        bus(3'h0, 8'h0f, 1'b1);
        pin_cmd <= 4'h0;
        repeat (4) @(posedge mclk_i);
        bus(3'h2, 8'hff, 1'b1);
        rd(3'h2, 8'h00);
        pin_cmd <= 4'h2;
        repeat (6) @(posedge mclk_i);
        rd(3'h2, 8'h02);
        bus(3'h2, 8'hff, 1'b1);
        rd(3'h2, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        bus(3'h5, seed[11:4], 1'b1);
        rd(3'h5, 8'h00);
        $display("interrupt test done");
        pin_cmd <= 4'h0;
        repeat (4) @(posedge mclk_i);
        req(1'b0);
        chk({6'h00, stop_o, wait_o}, 8'h01);
        pin_cmd <= 4'h8;
        wait_on(wake_o);
        chk({7'h00, wait_o}, 8'h00);
        pin_cmd <= 4'h0;
        req(1'b1);
        pin_cmd <= 4'h2;
        repeat (8) @(posedge mclk_i);
        chk({7'h00, stop_o}, 8'h01);
        pin_cmd <= 4'h1;
        wait_on(wake_o);
        chk({7'h00, stop_o}, 8'h00);
        $display("power test done");
        conclude();
    end
endmodule
bind rmli_top rmli_top_monitor u_rmli_top_monitor (.*);
